// ### core/bypass_channel_defs.vh
/*
 * Constants for one bypass channel control block.
 * Assumes a 50 MHz core clock and an Avalon-MM slave with 32-bit words.
 */
`ifndef BYPASS_CHANNEL_DEFS_VH
`define BYPASS_CHANNEL_DEFS_VH

// Register indices and byte addresses
`define CTRL_INDEX        8'h21
`define CTRL_ADDR         8'h84
`define IRQ_STATUS_ADDR   8'h88
`define IRQ_MASK_ADDR     8'h8c
`define IRQ_SOURCE_ADDR   8'h90
// Control register fields
`define BIT_CHAN_EN       7
`define BIT_DET_IRQ_EN    6
`define BIT_FORCE_BYPASS  1
`define BIT_SIG_DET       0
`define CTRL_WMASK        8'hc2
// Interrupt status fields
`define BIT_ST_DET_EDGE   0
`define BIT_ST_DET_LOSS   1
// Reset values
`define CTRL_RESET        8'h02
`define MASK_RESET        2'h0
// Timing
`define CLK_PERIOD_NS     20
`define MAX_LOSS_NS       400
`define MAX_LOSS_CYC      (`MAX_LOSS_NS / `CLK_PERIOD_NS)
`define FILTER_LEN        3

`endif

// ### core/bypass_channel.v
/*
 * One bypass channel: control register, detect input synchroniser and
 * filter, force-bypass output, interrupt status, mask and source.
 * Assumes pin inputs asynchronous to core_clk and an Avalon-MM master
 * that holds each request until waitrequest is low.
 */
`timescale 1ns/1ns
`default_nettype none
`include "bypass_channel_defs.vh"

////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Enable turns pins into bypass out, detect in
// - Enable overrides other pin settings, select included
// - Disabled: other bits do not touch pins
// - Detect edge with enable and detect irq enable: interrupt, source 21h
// - Detect edges without enable raise nothing
// - Enabled: bypass pin totem-pole from force bit
// - Force bit set keeps circuit normal
// - Force bit clear puts circuit in bypass
// - Enabled: filtered detect low clears force bit fast
// - Enabled: detect bit read-only pin level
// - Detect bit one means signal seen
// - Pin bits read through synchroniser and filter
// - Pins come up as pulled-up inputs
// - Force bit writable while detect stays high
module bypass_channel #(
	parameter FILTER_LEN = `FILTER_LEN
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        nrst,
	// Avalon-MM slave
	input  wire [7:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	input  wire [3:0]  byteenable,
	output reg  [31:0] readdata,
	output wire        waitrequest,
	// Other control registers for the bypass pin
	input  wire        gp_out_val,
	input  wire        gp_out_en,
	input  wire        bypass_select,
	// Bypass output pin
	input  wire        bypass_pin_in,
	output wire        bypass_pin_out,
	output wire        bypass_pin_oe,
	output wire        bypass_pin_pullup,
	// Detect input pin
	input  wire        detect_pin_in,
	output wire        detect_pin_out,
	output wire        detect_pin_oe,
	output wire        detect_pin_pullup,
	// Interrupt
	output wire        irq_n
);

	////////////////////////////////////////////////////////////////////
	// Registers
	reg                  chan_en_ff;
	reg                  det_irq_en_ff;
	reg                  force_bypass_ff;
	reg                  sync1_ff;
	reg                  sync2_ff;
	reg [FILTER_LEN-1:0] hist_ff;
	reg                  det_filt_ff;
	reg                  det_prev_ff;
	reg                  pin_sync1_ff;
	reg                  pin_sync2_ff;
	reg [FILTER_LEN-1:0] pin_hist_ff;
	reg                  pin_filt_ff;
	reg [1:0]            irq_status_ff;
	reg [1:0]            irq_mask_ff;
	reg [7:0]            irq_source_ff;
	reg                  ack_ff;

	reg                  nxt_det_filt;
	reg                  nxt_force_bypass;
	reg [1:0]            nxt_irq_status;
	reg [7:0]            nxt_irq_source;

	wire       access = (read | write) & ~ack_ff;
	wire       wr_ctl = write & ack_ff & (address == `CTRL_ADDR) & byteenable[0];
	wire       wr_msk = write & ack_ff & (address == `IRQ_MASK_ADDR) & byteenable[0];
	wire       rd_sts = read & ack_ff & (address == `IRQ_STATUS_ADDR);
	wire       det_edge = det_filt_ff ^ det_prev_ff;
	wire [7:0] ctrl_rd;
	wire       nxt_pin_filt;

	// Filter decision: follow the history once all samples agree
	function filt_next;
		input [FILTER_LEN-1:0] hist;
		input                  cur;
		begin
			filt_next = cur;
			if (&hist) begin
				filt_next = 1'b1;
			end else if (~|hist) begin
				filt_next = 1'b0;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Bus handshake: one wait cycle on every access
	assign waitrequest = (read | write) & ~ack_ff;

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= access;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Detect synchroniser and filter
	always @* begin
		nxt_det_filt = filt_next(hist_ff, det_filt_ff);
	end

	assign nxt_pin_filt = filt_next(pin_hist_ff, pin_filt_ff);

	// Bypass pin read-back synchroniser and filter
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pin_sync1_ff <= 1'b1;
			pin_sync2_ff <= 1'b1;
			pin_hist_ff  <= {FILTER_LEN{1'b1}};
			pin_filt_ff  <= 1'b1;
		end else begin
			pin_sync1_ff <= bypass_pin_in;
			pin_sync2_ff <= pin_sync1_ff;
			pin_hist_ff  <= {pin_hist_ff[FILTER_LEN-2:0], pin_sync2_ff};
			pin_filt_ff  <= nxt_pin_filt;
		end
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_ff    <= 1'b1;
			sync2_ff    <= 1'b1;
			hist_ff     <= {FILTER_LEN{1'b1}};
			det_filt_ff <= 1'b1;
			det_prev_ff <= 1'b1;
		end else begin
			sync1_ff    <= detect_pin_in;
			sync2_ff    <= sync1_ff;
			hist_ff     <= {hist_ff[FILTER_LEN-2:0], sync2_ff};
			det_filt_ff <= nxt_det_filt;
			det_prev_ff <= det_filt_ff;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control register
	always @* begin
		nxt_force_bypass = force_bypass_ff;
		if (wr_ctl) begin
			nxt_force_bypass = writedata[`BIT_FORCE_BYPASS];
		end
		if (chan_en_ff && !det_filt_ff) begin
			nxt_force_bypass = 1'b0;
		end
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			chan_en_ff      <= 1'b0;
			det_irq_en_ff   <= 1'b0;
			force_bypass_ff <= 1'b1;
			irq_mask_ff     <= `MASK_RESET;
		end else begin
			if (wr_ctl) begin
				chan_en_ff    <= writedata[`BIT_CHAN_EN];
				det_irq_en_ff <= writedata[`BIT_DET_IRQ_EN];
			end
			if (wr_msk) begin
				irq_mask_ff <= writedata[1:0];
			end
			force_bypass_ff <= nxt_force_bypass;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt status, source and output
	always @* begin
		nxt_irq_status = irq_status_ff;
		nxt_irq_source = irq_source_ff;
		// Clear only what the read returned, so an event in between is kept
		if (rd_sts) begin
			nxt_irq_status = irq_status_ff & ~readdata[1:0];
		end
		if (chan_en_ff && det_irq_en_ff && det_edge) begin
			nxt_irq_status[`BIT_ST_DET_EDGE] = 1'b1;
			nxt_irq_source = `CTRL_INDEX;
		end
		if (chan_en_ff && force_bypass_ff && !det_filt_ff) begin
			nxt_irq_status[`BIT_ST_DET_LOSS] = 1'b1;
		end
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_status_ff <= 2'h0;
			irq_source_ff <= 8'h00;
		end else begin
			irq_status_ff <= nxt_irq_status;
			irq_source_ff <= nxt_irq_source;
		end
	end

	assign irq_n = ~|(irq_status_ff & irq_mask_ff);

	////////////////////////////////////////////////////////////////////
	// Pins
	// Enabled: bypass pin driven from force bit, detect pin input only
	assign bypass_pin_oe  = chan_en_ff | (gp_out_en & ~bypass_select);
	assign bypass_pin_out = chan_en_ff ? force_bypass_ff : gp_out_val;
	assign bypass_pin_pullup = ~bypass_pin_oe;
	assign detect_pin_oe     = 1'b0;
	assign detect_pin_out    = 1'b0;
	assign detect_pin_pullup = 1'b1;

	////////////////////////////////////////////////////////////////////
	// Read data
	// Detect bit shows filtered pin level, one meaning signal present
	assign ctrl_rd = {chan_en_ff, det_irq_en_ff, 4'h0,
		chan_en_ff ? force_bypass_ff : pin_filt_ff, det_filt_ff};

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			readdata <= 32'h0000_0000;
		end else if (access && read) begin
			case (address)
				`CTRL_ADDR:       readdata <= {24'h000000, ctrl_rd};
				`IRQ_STATUS_ADDR: readdata <= {30'h0, irq_status_ff};
				`IRQ_MASK_ADDR:   readdata <= {30'h0, irq_mask_ff};
				`IRQ_SOURCE_ADDR: readdata <= {24'h000000, irq_source_ff};
				default:          readdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule // bypass_channel
`default_nettype wire

// ### testbench/bypass_far.sv
/* Far-side bypass circuit model. Assumes the pin floats high when undriven. */
`timescale 1ns/1ns
`default_nettype none
module bypass_far (
	input  wire logic core_clk, loss, out, oe,
	output var  logic detect,
	output wire logic lvl
);
	// Pulled up when idle; a low level puts the circuit in bypass
	assign lvl = oe ? out : 1'b1;
	always @(posedge core_clk) detect <= !loss;
endmodule // bypass_far
`default_nettype wire

// ### testbench/bypass_channel_props.sv
/* Port checks for bypass_channel. Assumes byteenable lane 0 is set. */
`timescale 1ns/1ns
`default_nettype none
module bypass_channel_props (
	input wire logic        core_clk, nrst, read, write, waitrequest, detect_pin_in,
	input wire logic [7:0]  address,
	input wire logic [31:0] writedata,
	input wire logic        gp_out_val, gp_out_en, bypass_select, bypass_pin_out,
	input wire logic        bypass_pin_oe, detect_pin_oe
);
	logic en_ff;
	wire  wr = write && !waitrequest && address == 8'h84;
	always @(posedge core_clk or negedge nrst)
		if (!nrst) en_ff <= 1'b0;
		else if (wr) en_ff <= writedata[7];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence hi8; detect_pin_in [*8]; endsequence
	sequence lost8; (en_ff && !detect_pin_in) [*8]; endsequence
	drive_on_a: assert property (en_ff && !bypass_select |-> bypass_pin_oe)
		else $error("pin idle");
	off_oe_a: assert property (!en_ff |-> bypass_pin_oe == (gp_out_en && !bypass_select))
		else $error("bad oe");
	off_val_a: assert property (!en_ff && bypass_pin_oe |-> bypass_pin_out == gp_out_val)
		else $error("bad out");
	det_in_a: assert property (!detect_pin_oe)
		else $error("detect driven");
	loss_clr_a: assert property (lost8 |-> !bypass_pin_out)
		else $error("no clear");
	fb_set_a: assert property (hi8 ##0 (wr && writedata[7] && writedata[1])
		|=> bypass_pin_out) else $error("not normal");
	fb_clr_a: assert property (wr && writedata[7] && !writedata[1] |=> !bypass_pin_out)
		else $error("not bypass");
	ack_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("late ack");
endmodule // bypass_channel_props
bind bypass_channel bypass_channel_props i_props (.core_clk, .nrst, .read, .write,
	.waitrequest, .detect_pin_in, .address, .writedata, .gp_out_val, .gp_out_en,
	.bypass_select, .bypass_pin_out, .bypass_pin_oe, .detect_pin_oe);
`default_nettype wire

// ### testbench/tb_port_bypass_control_channel.sv
/* Bench for bypass_channel. Assumes bypass_far and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module tb_port_bypass_control_channel;
	logic        core_clk = 0, nrst = 0, read = 0, write = 0, loss = 0, f;
	logic        gp_out_val = 0, gp_out_en = 0, bypass_select = 0;
	logic [7:0]  address = 0;
	logic [31:0] writedata = 0, rd;
	wire  [31:0] readdata;
	wire         waitrequest, pout, poe, lvl, det, irq_n;
	int          err_total = 0, num_checks = 0, cyc = 0;
	always #10 core_clk = ~core_clk;
	bypass_channel i_dut (.core_clk, .nrst, .address, .read, .write, .writedata,
		.byteenable(4'hf), .readdata, .waitrequest, .gp_out_val, .gp_out_en,
		.bypass_select, .bypass_pin_in(lvl), .bypass_pin_out(pout), .bypass_pin_oe(poe),
		.bypass_pin_pullup(), .detect_pin_in(det), .detect_pin_out(), .detect_pin_oe(),
		.detect_pin_pullup(), .irq_n);
	bypass_far i_far (.core_clk, .loss, .out(pout), .oe(poe), .detect(det), .lvl);
	function automatic logic [31:0] ctl(input logic e, i, fb, d);
		return {24'h0, e, i, 4'h0, fb, d};
	endfunction
	task automatic chk(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		write <= w;
		read <= !w;
		address <= a;
		writedata <= d;
		@(posedge core_clk);
		while (waitrequest !== 1'b0) @(posedge core_clk);
		rd = readdata;
		write <= 0;
		read <= 0;
		@(posedge core_clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
		bus(0, a, 0);
		chk(rd & m, e);
	endtask
	task automatic test_done;
		if (err_total == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge core_clk) if (++cyc == 3000) begin
		err_total++;
		test_done;
	end
	initial begin
		void'($urandom(29));
		repeat (3) @(posedge core_clk);
		nrst <= 1;
		@(posedge core_clk);
		rdc(8'h84, 32'hc3, ctl(0, 0, 1, 1));
		bus(1, 8'h84, {24'h0, 6'h2f, rd[1], 1'b0});
		rdc(8'h84, 32'hff, ctl(1, 0, 1, 1));
		repeat (16) begin
			f = 1'($urandom);
			{gp_out_val, gp_out_en} <= 2'($urandom);
			bus(1, 8'h84, {24'h0, 6'h20, f, 1'b0});
			chk(pout, f);
			rdc(8'h84, 32'hff, ctl(1, 0, f, 1));
		end
		bus(1, 8'h84, 32'h42);
		repeat (40) begin
			@(posedge core_clk);
			{bypass_select, gp_out_val, gp_out_en, loss} <= 4'($urandom);
		end
		@(posedge core_clk);
		{bypass_select, loss} <= 2'b00;
		repeat (20) @(posedge core_clk);
		rdc(8'h88, 32'h1, 32'h0);
		bus(1, 8'h84, 32'hc2);
		loss <= 1;
		repeat (20) @(posedge core_clk);
		chk(pout, 0);
		chk(irq_n, 1);
		rdc(8'h84, 32'hff, ctl(1, 1, 0, 0));
		rdc(8'h90, 32'hff, 32'h21);
		bus(1, 8'h8c, 32'h3);
		chk(irq_n, 0);
		loss <= 0;
		repeat (20) @(posedge core_clk);
		rdc(8'h88, 32'hff, 32'h3);
		rdc(8'h88, 32'hff, 32'h0);
		chk(irq_n, 1);
		bus(1, 8'h84, 32'h82);
		loss <= 1;
		repeat (20) @(posedge core_clk);
		loss <= 0;
		repeat (20) @(posedge core_clk);
		rdc(8'h88, 32'h1, 32'h0);
		rdc(8'h94, 32'hffffffff, 32'h0);
		test_done;
	end
endmodule // tb_port_bypass_control_channel
`default_nettype wire
